/* File: test/upcc_top_tb_top.sv */
// Self-checking bench of the uncore performance counter control
`timescale 1ns/10ps
`include "upcc_defs.svh"
`define CHK(nm, ex, gt) \
	begin \
		samples_checked++; \
		if ((gt) !== (ex)) \
		begin \
			failures++; \
			$display("[ERR] %s expected %0h seen %0h", nm, ex, gt); \
		end \
	end
module upcc_top_tb_top;
	logic                    i_clk;
	logic                    i_rst_n;
	logic [`UPCC_ADDR_W-1:0] i_msr_addr;
	logic                    i_msr_wr;
	logic                    i_msr_rd;
	logic [`UPCC_DATA_W-1:0] i_msr_wdata;
	logic [`UPCC_DATA_W-1:0] o_msr_rdata;
	logic                    o_msr_rvalid;
	logic                    o_msr_fault;
	logic [31:0]             i_cfg_sub;
	logic [31:0]             i_box_sub;
	logic                    o_box_frozen;
	int                      failures;
	int                      samples_checked;
	int                      seed = 67;
	longint                  acc [4];
	longint                  cyc;
	bit                      prev [4];
	logic [31:0]             ctl [4];
	bit                      frz_en;
	bit                      frz;
	logic [63:0]             d;
	longint                  s;
	logic [31:0]             cond [8] = '{32'h0040FF01, 32'h0040A503,
		32'h03400F04, 32'h03C0FF02, 32'h01440101, 32'h0040FF00,
		32'h0040FF05, 32'h0000FF01};
	logic [15:0]             rsta [7] = '{`UPCC_OFF_FIX_CTL,
		`UPCC_OFF_FIX_CTR, `UPCC_OFF_CTL0, `UPCC_OFF_CTL1, `UPCC_OFF_CTR0,
		`UPCC_OFF_CTR1, `UPCC_OFF_BOX_CTL};

	upcc_top dut_u
	(
		.i_clk        (i_clk),
		.i_rst_n      (i_rst_n),
		.i_msr_addr   (i_msr_addr),
		.i_msr_wr     (i_msr_wr),
		.i_msr_rd     (i_msr_rd),
		.i_msr_wdata  (i_msr_wdata),
		.o_msr_rdata  (o_msr_rdata),
		.o_msr_rvalid (o_msr_rvalid),
		.o_msr_fault  (o_msr_fault),
		.i_cfg_sub    (i_cfg_sub),
		.i_box_sub    (i_box_sub),
		.o_box_frozen (o_box_frozen)
	);

	// ==========================================================
	// Clock, random event lines, cycle count
	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	always @(posedge i_clk)
	begin
		i_cfg_sub <= $random(seed);
		i_box_sub <= $random(seed);
	end

	// ==========================================================
	// Reference model of the event conditioning
	function automatic int cinc(input logic [31:0] c, input logic [31:0] sb,
		input bit p, output bit cmp);
		int n;
		int v;
		int sel;
		logic [7:0] l;
		n = 0;
		sel = int'(c[7:0]);
		l = (sel >= 1 && sel <= 4) ? (sb[8*(sel-1) +: 8] & c[15:8]) : 8'h00;
		for (int i = 0; i < 8; i++)
			n += int'(l[i]);
		cmp = c[23] ? (n < int'(c[28:24])) : (n >= int'(c[28:24]));
		if (c[28:24] == 5'h00)
			v = n;
		else if (c[18])
			v = int'(cmp && !p);
		else
			v = int'(cmp);
		return c[22] ? v : 0;
	endfunction

	always @(posedge i_clk)
	begin
		bit cm;
		int v;
		cyc = cyc + 1;
		for (int k = 0; k < 4; k++)
		begin
			v = cinc(ctl[k], (k < 2) ? i_cfg_sub : i_box_sub, prev[k], cm);
			if (k < 2 || !(frz_en && frz))
				acc[k] += v;
			prev[k] = cm;
		end
	end

	// ==========================================================
	// Register access
	function automatic logic mapped(input logic [15:0] a);
		return a inside {`UPCC_OFF_FIX_CTL, `UPCC_OFF_FIX_CTR, `UPCC_OFF_CTL0,
			`UPCC_OFF_CTL1, `UPCC_OFF_CTR0, `UPCC_OFF_CTR1, `UPCC_OFF_BOX_CTL,
			`UPCC_OFF_BOX_CTL0, `UPCC_OFF_BOX_CTL1, `UPCC_OFF_BOX_CTR0,
			`UPCC_OFF_BOX_CTR1};
	endfunction

	task automatic wr(input logic [15:0] a, input logic [63:0] v);
		@(posedge i_clk);
		i_msr_wr    <= 1'b1;
		i_msr_addr  <= a;
		i_msr_wdata <= v;
		@(posedge i_clk);
		i_msr_wr <= 1'b0;
		case (a)
			`UPCC_OFF_CTL0:     ctl[0] = v[31:0];
			`UPCC_OFF_CTL1:     ctl[1] = v[31:0];
			`UPCC_OFF_BOX_CTL0: ctl[2] = v[31:0];
			`UPCC_OFF_BOX_CTL1: ctl[3] = v[31:0];
			`UPCC_OFF_BOX_CTL:  {frz_en, frz} = {v[16], v[8]};
			default:            ;
		endcase
		#1 `CHK("write fault", !mapped(a), o_msr_fault)
	endtask

	task automatic rd(input logic [15:0] a, output logic [63:0] q,
		output longint sn);
		@(posedge i_clk);
		i_msr_rd   <= 1'b1;
		i_msr_addr <= a;
		#1;
		case (a)
			`UPCC_OFF_CTR1:     sn = acc[1];
			`UPCC_OFF_BOX_CTR0: sn = acc[2];
			`UPCC_OFF_BOX_CTR1: sn = acc[3];
			`UPCC_OFF_FIX_CTR:  sn = cyc;
			default:            sn = acc[0];
		endcase
		@(posedge i_clk);
		i_msr_rd <= 1'b0;
		#1 `CHK("read valid", mapped(a), o_msr_rvalid)
		`CHK("read fault", !mapped(a), o_msr_fault)
		q = o_msr_rdata;
	endtask

	// Counts gained across a window, compared modulo the counter width
	task automatic win(input logic [15:0] a, input int n, input string nm);
		logic [63:0] d0;
		logic [63:0] d1;
		logic [63:0] m;
		longint s0;
		longint s1;
		m = (a == `UPCC_OFF_FIX_CTR) ? 64'h0000FFFFFFFFFFFF
			: 64'h00000FFFFFFFFFFF;
		rd(a, d0, s0);
		repeat (n) @(posedge i_clk);
		rd(a, d1, s1);
		`CHK(nm, 64'(s1 - s0) & m, (d1 - d0) & m)
		`CHK("upper bits", 64'h0, d1 & ~m)
	endtask

	task automatic results;
		if (failures == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ==========================================================
	// Watchdog
	initial
	begin
		#200000;
		failures++;
		results();
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		i_rst_n = 1'b0;
		i_msr_addr = 16'h0000;
		i_msr_wr = 1'b0;
		i_msr_rd = 1'b0;
		i_msr_wdata = 64'h0;
		i_cfg_sub = 32'h0;
		i_box_sub = 32'h0;
		cyc = 0;
		foreach (ctl[k])
			ctl[k] = 32'h0;
		repeat (5) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_clk);
		foreach (rsta[k])
		begin
			rd(rsta[k], d, s);
			`CHK("reset value", 64'h0, d)
		end
		rd(16'h0C12, d, s);
		`CHK("refused read data", 64'h0, d)
		wr(16'h0C13, 64'h00400000);
		wr(`UPCC_OFF_CTL1, 64'hFFFFFFFFFFFFFFFF);
		rd(`UPCC_OFF_CTL1, d, s);
		`CHK("control readback", 64'h000000001FC4FFFF, d)
		wr(`UPCC_OFF_CTL1, 64'h0);
		wr(`UPCC_OFF_CTR1, 64'h0);
		rd(`UPCC_OFF_CTR1, d, s);
		`CHK("counter cleared", 64'h0, d)
		foreach (cond[k])
		begin
			wr(`UPCC_OFF_CTL0, {32'h0, cond[k]});
			repeat (2) @(posedge i_clk);
			win(`UPCC_OFF_CTR0, 25, "config counter");
		end
		wr(`UPCC_OFF_CTL1, 64'h0040FF02);
		wr(`UPCC_OFF_CTR1, 64'hFFFFFFFFFFFFFF00);
		win(`UPCC_OFF_CTR1, 100, "config wrap");
		wr(`UPCC_OFF_FIX_CTL, 64'h00400000);
		win(`UPCC_OFF_FIX_CTR, 37, "fixed count");
		wr(`UPCC_OFF_FIX_CTR, 64'hFFFFFFFFFFFFFFF8);
		win(`UPCC_OFF_FIX_CTR, 20, "fixed wrap");
		wr(`UPCC_OFF_BOX_CTL0, 64'h0040FF01);
		wr(`UPCC_OFF_BOX_CTL1, 64'h0040F003);
		wr(`UPCC_OFF_BOX_CTL, 64'h00010100);
		repeat (2) @(posedge i_clk);
		#1 `CHK("frozen flag", 1'b1, o_box_frozen)
		win(`UPCC_OFF_BOX_CTR0, 20, "frozen box 0");
		win(`UPCC_OFF_BOX_CTR1, 20, "frozen box 1");
		wr(`UPCC_OFF_BOX_CTL, 64'h00010102);
		repeat (2) @(posedge i_clk);
		rd(`UPCC_OFF_BOX_CTR0, d, s);
		`CHK("box clear 0", 64'h0, d)
		rd(`UPCC_OFF_BOX_CTR1, d, s);
		`CHK("box clear 1", 64'h0, d)
		rd(`UPCC_OFF_BOX_CTL, d, s);
		`CHK("box control", 64'h00010100, d)
		wr(`UPCC_OFF_BOX_CTL, 64'h00000100);
		repeat (2) @(posedge i_clk);
		#1 `CHK("freeze ignored", 1'b0, o_box_frozen)
		win(`UPCC_OFF_BOX_CTR0, 20, "unaccepted box 0");
		win(`UPCC_OFF_BOX_CTR1, 20, "unaccepted box 1");
		wr(`UPCC_OFF_BOX_CTL, 64'h00010000);
		repeat (2) @(posedge i_clk);
		win(`UPCC_OFF_BOX_CTR0, 20, "resumed box 0");
		win(`UPCC_OFF_BOX_CTR1, 20, "resumed box 1");
		results();
	end
endmodule

/* File: verilog/upcc_cnt.sv */
// One wrapping event counter with clear and software load
`timescale 1ns/10ps
`include "upcc_defs.svh"
module upcc_cnt
#(
	parameter int W = `UPCC_PROG_W
)
(
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_clr,
	input  wire logic                   i_wr,
	input  wire logic [W-1:0]           i_wdata,
	input  wire logic                   i_en,
	input  wire logic [`UPCC_INC_W-1:0] i_inc,
	output logic      [W-1:0]           o_count
);

	// ==========================================================
	// Counter
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_count <= '0;
		else if (i_clr)
			o_count <= '0;
		else if (i_wr)
			o_count <= i_wdata;
		else if (i_en)
			o_count <= o_count + W'(i_inc);
	end

	// ==========================================================
	// Checks
	a_cnt_clear_zero: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		i_clr |=> (o_count == '0))
		else $error("counter not cleared");

	a_cnt_hold_off: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		(!i_en && !i_clr && !i_wr) |=> $stable(o_count))
		else $error("disabled counter moved");

endmodule

/* File: verilog/upcc_defs.svh */
// Offsets, field positions, widths and reset values of the counter block
`ifndef UPCC_DEFS_SVH
`define UPCC_DEFS_SVH

// ==========================================================
// Register offsets
`define UPCC_OFF_FIX_CTL 16'h0C08
`define UPCC_OFF_FIX_CTR 16'h0C09
`define UPCC_OFF_CTL0 16'h0C10
`define UPCC_OFF_CTL1 16'h0C11
`define UPCC_OFF_CTR0 16'h0C16
`define UPCC_OFF_CTR1 16'h0C17
`define UPCC_OFF_BOX_CTL 16'h0C44
`define UPCC_OFF_BOX_CTL0 16'h0C50
`define UPCC_OFF_BOX_CTL1 16'h0C51
`define UPCC_OFF_BOX_CTR0 16'h0C56
`define UPCC_OFF_BOX_CTR1 16'h0C57

// ==========================================================
// Control field positions
`define UPCC_F_THR_HI 28
`define UPCC_F_THR_LO 24
`define UPCC_F_INV 23
`define UPCC_F_EN 22
`define UPCC_F_EDGE 18
`define UPCC_F_RST 17
`define UPCC_F_UMASK_HI 15
`define UPCC_F_UMASK_LO 8
`define UPCC_F_EVENT_HI 7
`define UPCC_F_EVENT_LO 0
`define UPCC_F_FRZ_EN 16
`define UPCC_F_FRZ 8
`define UPCC_F_BOXRST_HI 1
`define UPCC_F_BOXRST_LO 0

// ==========================================================
// Writable masks and reset values
`define UPCC_CTL_WMASK 32'h1FC4FFFF
`define UPCC_CTL_RST 32'h00000000

// ==========================================================
// Widths and counts
`define UPCC_ADDR_W 16
`define UPCC_DATA_W 64
`define UPCC_PROG_W 44
`define UPCC_FIX_W 48
`define UPCC_INC_W 4
`define UPCC_THR_W 5
`define UPCC_SUB_W 8
`define UPCC_NUM_EV 4
`define UPCC_NUM_CNT 4
`define UPCC_NUM_CFG 2

`endif

/* File: verilog/upcc_evt_cond.sv */
// Threshold, invert and edge conditioning of one event increment
`timescale 1ns/10ps
`include "upcc_defs.svh"
module upcc_evt_cond
(
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_n,
	input  wire logic [`UPCC_INC_W-1:0] i_inc,
	input  wire logic [`UPCC_THR_W-1:0] i_thresh,
	input  wire logic                   i_invert,
	input  wire logic                   i_edge,
	output logic      [`UPCC_INC_W-1:0] o_inc
);

	logic cmp;
	logic prev;

	// ==========================================================
	// Comparison and edge
	always_comb
	begin
		if (i_invert)
			cmp = {1'b0, i_inc} < i_thresh;
		else
			cmp = {1'b0, i_inc} >= i_thresh;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			prev <= 1'b0;
		else
			prev <= cmp;
	end

	always_comb
	begin
		if (i_thresh == '0)
			o_inc = i_inc;
		else if (i_edge)
			o_inc = {{(`UPCC_INC_W-1){1'b0}}, cmp & ~prev};
		else
			o_inc = {{(`UPCC_INC_W-1){1'b0}}, cmp};
	end

	// ==========================================================
	// Checks
	a_cond_thresh_one: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		(i_thresh != 5'h00) |-> (o_inc <= 4'h1))
		else $error("thresholded increment above one");

	a_cond_edge_once: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		(i_thresh != 5'h00 && i_edge && o_inc != 4'h0)
		##1 ($stable(i_thresh) && $stable(i_edge) && $stable(i_invert))
		|-> (o_inc == 4'h0))
		else $error("edge detect counted twice in a row");

endmodule

/* File: verilog/upcc_pkg.sv */
// Types shared by the counter block
`include "upcc_defs.svh"
package upcc_pkg;

	// ==========================================================
	// Box reset codes
	typedef enum logic [1:0]
	{
		UPCC_BOXRST_NONE  = 2'h0,
		UPCC_BOXRST_CLEAR = 2'h2
	} upcc_boxrst_t;

	// ==========================================================
	// Register selected by an address
	typedef enum logic [3:0]
	{
		UPCC_REG_FIX_CTL = 4'h0,
		UPCC_REG_FIX_CTR = 4'h1,
		UPCC_REG_CTL0    = 4'h2,
		UPCC_REG_CTL1    = 4'h3,
		UPCC_REG_CTL2    = 4'h4,
		UPCC_REG_CTL3    = 4'h5,
		UPCC_REG_CTR0    = 4'h6,
		UPCC_REG_CTR1    = 4'h7,
		UPCC_REG_CTR2    = 4'h8,
		UPCC_REG_CTR3    = 4'h9,
		UPCC_REG_BOX_CTL = 4'hA,
		UPCC_REG_NONE    = 4'hF
	} upcc_reg_t;

	typedef logic [`UPCC_PROG_W-1:0] upcc_prog_t;
	typedef logic [`UPCC_FIX_W-1:0]  upcc_fix_t;

endpackage

/* File: verilog/upcc_top.sv */
// Uncore performance counter control: config unit and one frozen box
//
// Function
// - No interrupt or sampling output; software only reads counters.
// - After reset every counter is disabled until software enables it.
// - A counter counts only if enabled and its box not frozen.
// - Freeze acts only while the box freeze-accept bit is 1.
// - Accepted freeze holds all box counters at their values.
// - Clearing freeze lets enabled box counters resume counting.
// - Each counter has its own enable bit; 1 permits counting.
// - Control holds event select, subevent mask, threshold, edge, invert.
// - Writing 0x2 to box control bits 1:0 clears box counters.
// - Counter data registers are writable so software can zero them.
// - Config unit counters run once enabled with a valid event.
// - Counters are readable at any time without stopping them.
// - Config unit has two 44-bit counters selecting any unit event.
// - A 48-bit fixed counter adds one per uncore clock when enabled.
// - Nonzero threshold turns increment into one if it meets threshold.
// - With nonzero threshold, edge detect counts only a no-event to event transition.
// - Carry out of the top bit is dropped, so the counter wraps past zero.
`timescale 1ns/10ps
`include "upcc_defs.svh"
module upcc_top
(
	input  wire logic                                 i_clk,
	input  wire logic                                 i_rst_n,
	input  wire logic [`UPCC_ADDR_W-1:0]              i_msr_addr,
	input  wire logic                                 i_msr_wr,
	input  wire logic                                 i_msr_rd,
	input  wire logic [`UPCC_DATA_W-1:0]              i_msr_wdata,
	output logic      [`UPCC_DATA_W-1:0]              o_msr_rdata,
	output logic                                      o_msr_rvalid,
	output logic                                      o_msr_fault,
	input  wire logic [`UPCC_NUM_EV*`UPCC_SUB_W-1:0]  i_cfg_sub,
	input  wire logic [`UPCC_NUM_EV*`UPCC_SUB_W-1:0]  i_box_sub,
	output logic                                      o_box_frozen
);

	// ==========================================================
	// Address decode
	function automatic upcc_pkg::upcc_reg_t decode
	(
		input logic [`UPCC_ADDR_W-1:0] addr
	);
		upcc_pkg::upcc_reg_t r;
		case (addr)
			`UPCC_OFF_FIX_CTL:  r = upcc_pkg::UPCC_REG_FIX_CTL;
			`UPCC_OFF_FIX_CTR:  r = upcc_pkg::UPCC_REG_FIX_CTR;
			`UPCC_OFF_CTL0:     r = upcc_pkg::UPCC_REG_CTL0;
			`UPCC_OFF_CTL1:     r = upcc_pkg::UPCC_REG_CTL1;
			`UPCC_OFF_BOX_CTL0: r = upcc_pkg::UPCC_REG_CTL2;
			`UPCC_OFF_BOX_CTL1: r = upcc_pkg::UPCC_REG_CTL3;
			`UPCC_OFF_CTR0:     r = upcc_pkg::UPCC_REG_CTR0;
			`UPCC_OFF_CTR1:     r = upcc_pkg::UPCC_REG_CTR1;
			`UPCC_OFF_BOX_CTR0: r = upcc_pkg::UPCC_REG_CTR2;
			`UPCC_OFF_BOX_CTR1: r = upcc_pkg::UPCC_REG_CTR3;
			`UPCC_OFF_BOX_CTL:  r = upcc_pkg::UPCC_REG_BOX_CTL;
			default:            r = upcc_pkg::UPCC_REG_NONE;
		endcase
		return r;
	endfunction

	// ==========================================================
	// Event pick: masked subevent lines of the selected event
	function automatic logic [`UPCC_INC_W-1:0] evt_inc
	(
		input logic [`UPCC_NUM_EV*`UPCC_SUB_W-1:0] subs,
		input logic [`UPCC_SUB_W-1:0]              sel,
		input logic [`UPCC_SUB_W-1:0]              mask
	);
		logic [`UPCC_SUB_W-1:0] lines;
		logic [`UPCC_INC_W-1:0] sum;
		lines = '0;
		sum = '0;
		for (int e = 0; e < `UPCC_NUM_EV; e++)
			if (sel == `UPCC_SUB_W'(e + 1))
				lines = subs[e*`UPCC_SUB_W +: `UPCC_SUB_W] & mask;
		for (int b = 0; b < `UPCC_SUB_W; b++)
			sum = sum + `UPCC_INC_W'(lines[b]);
		return sum;
	endfunction

	upcc_pkg::upcc_reg_t          sel;
	logic                         hit;
	logic                         wr_hit;
	logic [31:0]                  ctl [`UPCC_NUM_CNT];
	logic                         fix_en;
	logic                         box_frz_en;
	logic                         box_frz;
	logic                         box_rst_wr;
	logic [`UPCC_NUM_CNT-1:0]     clr;
	logic [`UPCC_NUM_CNT-1:0]     cwr;
	logic [`UPCC_INC_W-1:0]       cond_inc [`UPCC_NUM_CNT];
	upcc_pkg::upcc_prog_t         cnt [`UPCC_NUM_CNT];
	upcc_pkg::upcc_fix_t          fix_cnt;
	logic                         fix_wr;
	logic [`UPCC_DATA_W-1:0]      next_rdata;

	assign sel = decode(i_msr_addr);
	assign hit = (sel != upcc_pkg::UPCC_REG_NONE);
	assign wr_hit = i_msr_wr & hit;
	assign fix_wr = wr_hit & (sel == upcc_pkg::UPCC_REG_FIX_CTR);
	assign box_rst_wr = wr_hit & (sel == upcc_pkg::UPCC_REG_BOX_CTL) &
		(i_msr_wdata[`UPCC_F_BOXRST_HI:`UPCC_F_BOXRST_LO] ==
		upcc_pkg::UPCC_BOXRST_CLEAR);

	// ==========================================================
	// Counter control registers
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			for (int k = 0; k < `UPCC_NUM_CNT; k++)
				ctl[k] <= `UPCC_CTL_RST;
		end
		else if (wr_hit)
		begin
			for (int k = 0; k < `UPCC_NUM_CNT; k++)
				if (4'(sel) == 4'(upcc_pkg::UPCC_REG_CTL0) + 4'(k))
					ctl[k] <= i_msr_wdata[31:0] & `UPCC_CTL_WMASK;
		end
	end

	// ==========================================================
	// Fixed counter control
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			fix_en <= 1'b0;
		else if (wr_hit && sel == upcc_pkg::UPCC_REG_FIX_CTL)
			fix_en <= i_msr_wdata[`UPCC_F_EN];
	end

	// ==========================================================
	// Box control: freeze accept and freeze
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			box_frz_en <= 1'b0;
			box_frz <= 1'b0;
			o_box_frozen <= 1'b0;
		end
		else if (wr_hit && sel == upcc_pkg::UPCC_REG_BOX_CTL)
		begin
			box_frz_en <= i_msr_wdata[`UPCC_F_FRZ_EN];
			box_frz <= i_msr_wdata[`UPCC_F_FRZ];
			o_box_frozen <= i_msr_wdata[`UPCC_F_FRZ_EN] &
				i_msr_wdata[`UPCC_F_FRZ];
		end
	end

	// ==========================================================
	// Programmable counters: two config unit, two box
	generate
		for (genvar gi = 0; gi < `UPCC_NUM_CNT; gi++)
		begin : g_cnt
			localparam bit IN_BOX = (gi >= `UPCC_NUM_CFG);
			logic [`UPCC_INC_W-1:0] raw_inc;
			logic                   run;

			assign raw_inc = evt_inc(IN_BOX ? i_box_sub : i_cfg_sub,
				ctl[gi][`UPCC_F_EVENT_HI:`UPCC_F_EVENT_LO],
				ctl[gi][`UPCC_F_UMASK_HI:`UPCC_F_UMASK_LO]);
			// Enabled counter runs; box counters stop while the box is frozen
			assign run = ctl[gi][`UPCC_F_EN] &
				~(IN_BOX & o_box_frozen);
			assign clr[gi] = (wr_hit &&
				4'(sel) == 4'(upcc_pkg::UPCC_REG_CTL0) + 4'(gi) &&
				i_msr_wdata[`UPCC_F_RST]) ||
				(IN_BOX && box_rst_wr);
			assign cwr[gi] = wr_hit &&
				4'(sel) == 4'(upcc_pkg::UPCC_REG_CTR0) + 4'(gi);

			upcc_evt_cond u_cond
			(
				.i_clk    (i_clk),
				.i_rst_n  (i_rst_n),
				.i_inc    (raw_inc),
				.i_thresh (ctl[gi][`UPCC_F_THR_HI:`UPCC_F_THR_LO]),
				.i_invert (ctl[gi][`UPCC_F_INV]),
				.i_edge   (ctl[gi][`UPCC_F_EDGE]),
				.o_inc    (cond_inc[gi])
			);

			upcc_cnt #(.W(`UPCC_PROG_W)) u_cnt
			(
				.i_clk   (i_clk),
				.i_rst_n (i_rst_n),
				.i_clr   (clr[gi]),
				.i_wr    (cwr[gi]),
				.i_wdata (i_msr_wdata[`UPCC_PROG_W-1:0]),
				.i_en    (run),
				.i_inc   (cond_inc[gi]),
				.o_count (cnt[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Fixed uncore clock counter
	upcc_cnt #(.W(`UPCC_FIX_W)) u_fix
	(
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_clr   (1'b0),
		.i_wr    (fix_wr),
		.i_wdata (i_msr_wdata[`UPCC_FIX_W-1:0]),
		.i_en    (fix_en),
		.i_inc   (`UPCC_INC_W'(1)),
		.o_count (fix_cnt)
	);

	// ==========================================================
	// Read path, live values
	always_comb
	begin
		case (sel)
			upcc_pkg::UPCC_REG_FIX_CTL:
				next_rdata = `UPCC_DATA_W'(fix_en) << `UPCC_F_EN;
			upcc_pkg::UPCC_REG_FIX_CTR:
				next_rdata = `UPCC_DATA_W'(fix_cnt);
			upcc_pkg::UPCC_REG_CTL0:
				next_rdata = `UPCC_DATA_W'(ctl[0]);
			upcc_pkg::UPCC_REG_CTL1:
				next_rdata = `UPCC_DATA_W'(ctl[1]);
			upcc_pkg::UPCC_REG_CTL2:
				next_rdata = `UPCC_DATA_W'(ctl[2]);
			upcc_pkg::UPCC_REG_CTL3:
				next_rdata = `UPCC_DATA_W'(ctl[3]);
			upcc_pkg::UPCC_REG_CTR0:
				next_rdata = `UPCC_DATA_W'(cnt[0]);
			upcc_pkg::UPCC_REG_CTR1:
				next_rdata = `UPCC_DATA_W'(cnt[1]);
			upcc_pkg::UPCC_REG_CTR2:
				next_rdata = `UPCC_DATA_W'(cnt[2]);
			upcc_pkg::UPCC_REG_CTR3:
				next_rdata = `UPCC_DATA_W'(cnt[3]);
			upcc_pkg::UPCC_REG_BOX_CTL:
				next_rdata = (`UPCC_DATA_W'(box_frz_en) << `UPCC_F_FRZ_EN) |
					(`UPCC_DATA_W'(box_frz) << `UPCC_F_FRZ);
			default:
				next_rdata = '0;
		endcase
	end

	// No interrupt path: data leaves only through reads
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_msr_rdata <= '0;
			o_msr_rvalid <= 1'b0;
			o_msr_fault <= 1'b0;
		end
		else
		begin
			o_msr_rvalid <= i_msr_rd & hit;
			o_msr_fault <= (i_msr_rd | i_msr_wr) & ~hit;
			if (i_msr_rd && hit)
				o_msr_rdata <= next_rdata;
		end
	end

	// ==========================================================
	// Checks
	a_rst_all_off: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		$rose(i_rst_n) |-> (!fix_en && !ctl[0][`UPCC_F_EN] &&
		!ctl[1][`UPCC_F_EN] && !ctl[2][`UPCC_F_EN] &&
		!ctl[3][`UPCC_F_EN]))
		else $error("counter enabled straight after reset");

	a_freeze_holds: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		(o_box_frozen && clr[3:2] == 2'h0 && cwr[3:2] == 2'h0)
		|=> ($stable(cnt[2]) && $stable(cnt[3])))
		else $error("frozen box counter moved");

	a_frz_en_gate: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		(!box_frz_en && ctl[2][`UPCC_F_EN] && cond_inc[2] != 4'h0 &&
		!clr[2] && !cwr[2])
		|=> (cnt[2] != $past(cnt[2])))
		else $error("box counter stopped without freeze accept");

	a_box_reset: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		(i_msr_wr && sel == upcc_pkg::UPCC_REG_BOX_CTL &&
		i_msr_wdata[1:0] == 2'h2)
		|=> (cnt[2] == '0 && cnt[3] == '0))
		else $error("box reset code did not clear counters");

	a_fix_ticks: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		(fix_en && !fix_wr) |=> (fix_cnt == $past(fix_cnt) + 48'h1))
		else $error("fixed counter missed an uncore clock");

	a_cfg_counts: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		(ctl[0][`UPCC_F_EN] && cond_inc[0] == 4'h1 && !clr[0] && !cwr[0])
		|=> (cnt[0] == $past(cnt[0]) + 44'h1))
		else $error("config unit counter did not count");

	a_read_live: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		(i_msr_rd && sel == upcc_pkg::UPCC_REG_CTR0)
		|=> (o_msr_rvalid && o_msr_rdata[63:44] == 20'h00000 &&
		o_msr_rdata[43:0] == $past(cnt[0])))
		else $error("counter read did not return live value");

	a_cfg_no_freeze: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		(o_box_frozen && ctl[1][`UPCC_F_EN] && cond_inc[1] != 4'h0 &&
		!clr[1] && !cwr[1])
		|=> (cnt[1] != $past(cnt[1])))
		else $error("config unit counter stopped by box freeze");

	a_unfrz_runs: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		(!o_box_frozen && ctl[3][`UPCC_F_EN] && cond_inc[3] != 4'h0 &&
		!clr[3] && !cwr[3])
		|=> (cnt[3] != $past(cnt[3])))
		else $error("unfrozen box counter did not resume");

	a_frz_same_cycle: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		(ctl[2][`UPCC_F_EN] && ctl[3][`UPCC_F_EN] &&
		cond_inc[2] != 4'h0 && cond_inc[3] != 4'h0 &&
		clr[3:2] == 2'h0 && cwr[3:2] == 2'h0)
		|=> ((cnt[2] == $past(cnt[2])) == (cnt[3] == $past(cnt[3]))))
		else $error("box counters froze in different cycles");

	a_fix_hold_off: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		(!fix_en && !fix_wr) |=> $stable(fix_cnt))
		else $error("disabled fixed counter moved");

	a_read_box: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		(i_msr_rd && sel == upcc_pkg::UPCC_REG_CTR2)
		|=> (o_msr_rvalid && o_msr_rdata[43:0] == $past(cnt[2])))
		else $error("box counter read did not return live value");

endmodule
